// >>> aop_pkg.sv
package aop_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ      = 100;
    localparam int CONV_NORM_US = 1000;  // normal service period per point
    localparam int CONV_FAST_US = 250;   // high-speed service period
    localparam int BLINK_MS     = 250;   // indicator flash half period

    // ------------------------------------------------------------------
    // geometry and value limits
    // ------------------------------------------------------------------
    localparam int NCH          = 8;
    localparam int NV_WORDS     = 64;
    localparam int FS           = 4095;  // full-scale converter code
    localparam int BIP_MIN      = -2048;
    localparam int BIP_MAX      = 2047;
    localparam int BIP_OFS      = 2048;
    localparam int RAMP_MIN     = 8;
    localparam int RAMP_BCD_MAX = 7999;
    localparam int RAMP_BIN_MAX = 32767;
    localparam int WR_WARN      = 5000;  // first flash threshold
    localparam logic [13:0] WCNT_MAX = 14'h3fff;
    localparam logic [16:0] RAMP_K = 17'(FS * CONV_NORM_US / 1000);

    // ------------------------------------------------------------------
    // register map: 8 words per point, globals above
    // ------------------------------------------------------------------
    localparam logic [2:0]  RI_DATA = 3'h0;
    localparam logic [2:0]  RI_SLO  = 3'h1;
    localparam logic [2:0]  RI_SHI  = 3'h2;
    localparam logic [2:0]  RI_LLO  = 3'h3;
    localparam logic [2:0]  RI_LHI  = 3'h4;
    localparam logic [2:0]  RI_RAMP = 3'h5;
    localparam logic [2:0]  RI_CFG  = 3'h6;
    localparam logic [2:0]  RI_OUT  = 3'h7;
    localparam logic [11:0] A_CTRL  = 12'h100;
    localparam logic [11:0] A_STAT  = 12'h104;
    localparam logic [11:0] A_WCNT  = 12'h108;

    // per-point configuration bits
    localparam int CF_BCD = 0;
    localparam int CF_SCL = 1;
    localparam int CF_LIM = 2;
    localparam int CF_RMP = 3;
    localparam int CF_BIP = 4;
    // control bits
    localparam int CT_FAST  = 0;
    localparam int CT_STORE = 1;
    // status bits
    localparam int SB_BUSY = 0;
    localparam int SB_MEM  = 1;
    localparam int SB_FLD  = 2;
    localparam int SB_HSC  = 3;
    localparam int SB_FAST = 4;
    localparam int SB_SET  = 8;
    localparam int SB_RNG  = 16;

    typedef enum logic [1:0] {NV_LOAD, NV_RUN, NV_STORE} aop_nv_t;

endpackage

// >>> aop_core.sv
`timescale 1ns/100ps
// Operation
// [R01] eight points, each with own data word and own configuration
// [R02] per-point BCD or two's-complement format for data and parameters
// [R03] binary scaling limits span -32767..32767; data between is eng units
// [R04] lower limit above upper gives reverse scaling, lower is full scale
// [R05] ramp enabled: output moves toward target at limited rate
// [R06] ramp time 8..7999 ms BCD, 8..32767 ms binary
// [R07] limiting enabled: data beyond limits clamps output constant
// [R08] limits apply in engineering units together with scaling
// [R09] host sets upper limit strictly above lower limit
// [R10] high-speed for all points, only with no scaling, limit or ramp
// [R11] store request bit copies working registers to non-volatile store
// [R12] power-on loads non-volatile store into working registers
// [R13] count store operations; flash run indicator from 5000 onward
// [R14] run indicator lit when normal; any error darkens it and stops
// [R15] error indicator on memory fault, bad settings, field supply loss
// [R16] unipolar range indicator when data below 0 or above 4095
// [R17] bipolar range indicator when data below -2048 or above 2047
// [R18] with scaling, range indicator when data outside scaling span
// [R19] hold option keeps last outputs after host power loss
// [R20] scaling maps engineering data to 0..100 percent of output span
// [R21] BCD signed -7999..7999, top digit F marks negative; decode gives -999..9999
// [R22] ramp restarts from present output at a step from ramp time
module aop_core
    import aop_pkg::*;
#(
    parameter int P_CONV_CYC  = CONV_NORM_US * CLK_MHZ,
    parameter int P_FAST_CYC  = CONV_FAST_US * CLK_MHZ,
    parameter int P_BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [11:0]           i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    output logic                       o_nv_req,
    output logic                       o_nv_we,
    output logic      [5:0]            o_nv_addr,
    output logic      [15:0]           o_nv_wdata,
    input  wire logic                  i_nv_ack,
    input  wire logic [15:0]           i_nv_rdata,
    input  wire logic                  i_nv_err,
    input  wire logic                  i_host_pwr_ok,
    input  wire logic                  i_field_pwr_ok,
    input  wire logic                  i_hold_sel,
    output logic      [NCH-1:0][11:0]  o_dac_code,
    output logic                       o_dac_fast,
    output logic                       o_run_led,
    output logic                       o_err_led,
    output logic                       o_range_led
);

    localparam int TW = $clog2(P_CONV_CYC + 1);
    localparam logic [TW-1:0] TL_N = TW'(P_CONV_CYC / NCH - 1);
    localparam logic [TW-1:0] TL_F = TW'(P_FAST_CYC / NCH - 1);
    localparam int BW = $clog2(P_BLINK_CYC + 1);
    localparam logic [BW-1:0] BL_N = BW'(P_BLINK_CYC - 1);

    logic [2:0]      pin_m_q, pin_s_q;
    logic [15:0]     rf_q [0:NV_WORDS-1];
    logic [1:0]      ctrl_q;
    logic            rdy_q, err_q, store_pend_q, mem_err_q;
    logic [31:0]     rd_q;
    aop_nv_t         nv_st_q;
    logic [5:0]      idx_q;
    logic            req_q, we_q;
    logic [15:0]     wdat_q;
    logic [13:0]     wcnt_q;
    logic [TW-1:0]   tick_q;
    logic [2:0]      ch_q;
    logic [NCH-1:0]  set_err_q, rng_q;
    logic [NCH-1:0][11:0] out_q;
    logic [BW-1:0]   blk_q;
    logic            blink_q, fast_q, run_q, errl_q, rngl_q;

    // ------------------------------------------------------------------
    // pin synchronisers: host power, field supply, hold switch
    // ------------------------------------------------------------------
    // reset assumes power good so a reset cannot fake a power loss
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            pin_m_q <= 3'h3;
            pin_s_q <= 3'h3;
        end else begin
            pin_m_q <= {i_hold_sel, i_field_pwr_ok, i_host_pwr_ok};
            pin_s_q <= pin_m_q;
        end
    end
    wire host_ok  = pin_s_q[0];
    wire field_ok = pin_s_q[1];
    wire hold_sel = pin_s_q[2];

    // ------------------------------------------------------------------
    // apb slave: one wait state so read data comes from a flop
    // ------------------------------------------------------------------
    wire        acc    = i_psel & i_penable;
    wire        wr_go  = acc & rdy_q & i_pwrite;
    wire        algn   = i_paddr[1:0] == 2'h0;
    wire        is_ch  = algn & (i_paddr[11:8] == 4'h0);
    wire        is_ctl = i_paddr == A_CTRL;
    wire        is_st  = i_paddr == A_STAT;
    wire        is_wc  = i_paddr == A_WCNT;
    wire        hit    = is_ch | is_ctl | is_st | is_wc;
    wire [5:0]  ridx   = i_paddr[7:2];
    wire        is_out = ridx[2:0] == RI_OUT;
    wire        running = nv_st_q == NV_RUN;
    wire        hsc;
    wire        err_any;
    logic [31:0] stat_w;

    assign stat_w[SB_BUSY] = !running;
    assign stat_w[SB_MEM]  = mem_err_q;
    assign stat_w[SB_FLD]  = !field_ok;
    assign stat_w[SB_HSC]  = hsc;
    assign stat_w[SB_FAST] = fast_q;
    assign stat_w[SB_SET-1:SB_FAST+1] = '0;
    assign stat_w[SB_RNG-1:SB_SET]    = set_err_q;
    assign stat_w[SB_RNG+NCH-1:SB_RNG] = rng_q;
    assign stat_w[31:SB_RNG+NCH]      = '0;

    wire [31:0] ch_rd = is_out ? {20'h0, out_q[ridx[5:3]]}
                               : {16'h0, rf_q[ridx]};
    wire [31:0] rd_w  = is_ch  ? ch_rd
                      : is_ctl ? {30'h0, ctrl_q}
                      : is_st  ? stat_w
                      : is_wc  ? {18'h0, wcnt_q} : 32'h0;

    // answer in the second access cycle; unmapped gives slverr
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rd_q  <= 32'h0;
        end else begin
            rdy_q <= acc & !rdy_q;
            err_q <= acc & !rdy_q & !hit;
            rd_q  <= (acc & !rdy_q & hit & !i_pwrite) ? rd_w : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // working registers, filled by software or by power-on load
    // ------------------------------------------------------------------
    wire ld_we = (nv_st_q == NV_LOAD) & req_q & i_nv_ack;
    wire ch_we = wr_go & is_ch & !is_out;
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < NV_WORDS; i++) rf_q[i] <= 16'h0;
        end else if (ch_we) begin
            rf_q[ridx] <= i_pwdata[15:0];  // R01
        end else if (ld_we) begin
            rf_q[idx_q] <= i_nv_rdata;  // R12
        end
    end

    // a 0 to 1 edge on the store bit asks for one copy; set beats clear
    wire store_req = wr_go & is_ctl & i_pwdata[CT_STORE] & !ctrl_q[CT_STORE];
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ctrl_q       <= 2'h0;
            store_pend_q <= 1'b0;
        end else begin
            if (wr_go & is_ctl) ctrl_q <= i_pwdata[1:0];
            store_pend_q <= store_req | (store_pend_q & !running);  // R11
        end
    end

    // ------------------------------------------------------------------
    // non-volatile sequencer: load at power-on, store on request
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            nv_st_q   <= NV_LOAD;
            idx_q     <= 6'h0;
            req_q     <= 1'b0;
            we_q      <= 1'b0;
            wdat_q    <= 16'h0;
            wcnt_q    <= 14'h0;
            mem_err_q <= 1'b0;
        end else begin
            if (req_q & i_nv_ack & i_nv_err) mem_err_q <= 1'b1;  // R15
            unique case (nv_st_q)
                NV_RUN: begin
                    if (store_pend_q) begin
                        nv_st_q <= NV_STORE;  // R11
                        idx_q   <= 6'h0;
                    end
                end
                NV_LOAD, NV_STORE: begin
                    if (!req_q) begin
                        req_q  <= 1'b1;
                        we_q   <= nv_st_q == NV_STORE;
                        wdat_q <= rf_q[idx_q];
                    end else if (i_nv_ack) begin
                        req_q <= 1'b0;
                        idx_q <= idx_q + 6'h1;
                        if (idx_q == 6'(NV_WORDS - 1)) begin
                            nv_st_q <= NV_RUN;
                            if (nv_st_q == NV_STORE && wcnt_q != WCNT_MAX)
                                wcnt_q <= wcnt_q + 14'h1;  // R13
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // point scheduler: one point served per tick, round robin
    // ------------------------------------------------------------------
    wire [TW-1:0] tlim = fast_q ? TL_F : TL_N;
    wire          tick = tick_q == tlim;
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            tick_q <= '0;
            ch_q   <= 3'h0;
        end else begin
            tick_q <= tick ? '0 : tick_q + 1'b1;
            if (tick) ch_q <= ch_q + 3'h1;
        end
    end

    // decode one word as BCD (top digit f = negative) or binary
    function automatic logic [17:0] dec(input logic [15:0] v,
                                        input logic bcd);
        logic [16:0] m;
        logic        e;
        m = 17'(v[11:8]) * 17'd100 + 17'(v[7:4]) * 17'd10 + 17'(v[3:0]);
        e = (v[11:8] > 4'h9) | (v[7:4] > 4'h9) | (v[3:0] > 4'h9);
        if (!bcd)
            dec = {1'b0, v[15], v};
        else if (v[15:12] == 4'hf)
            dec = {e, -m};  // R21
        else
            dec = {e | (v[15:12] > 4'h9), m + 17'(v[15:12]) * 17'd1000};
    endfunction

    // ------------------------------------------------------------------
    // data path for the point being served
    // ------------------------------------------------------------------
    wire [15:0] cfg = rf_q[{ch_q, RI_CFG}];
    wire        bcd = cfg[CF_BCD];
    wire        scl = cfg[CF_SCL];
    wire        lim = cfg[CF_LIM];
    wire        rmp = cfg[CF_RMP];
    wire        bip = cfg[CF_BIP];
    logic [17:0] dw [0:5];
    logic [NCH-1:0] feat;

    for (genvar k = 0; k < 6; k++) begin : g_dec
        assign dw[k] = dec(rf_q[{ch_q, 3'(k)}], bcd);  // R02
    end
    for (genvar c = 0; c < NCH; c++) begin : g_feat
        assign feat[c] = |rf_q[{3'(c), RI_CFG}][CF_RMP:CF_SCL];
    end

    // high speed is refused while any point uses a slow feature
    assign hsc = ctrl_q[CT_FAST] & (|feat);  // R10

    wire signed [16:0] dat = dw[RI_DATA][16:0];
    wire signed [16:0] slo = dw[RI_SLO][16:0];
    wire signed [16:0] shi = dw[RI_SHI][16:0];
    wire signed [16:0] llo = dw[RI_LLO][16:0];
    wire signed [16:0] lhi = dw[RI_LHI][16:0];
    wire signed [16:0] rmv = dw[RI_RAMP][16:0];
    wire               rev = slo > shi;  // R04
    wire signed [16:0] smin = rev ? shi : slo;
    wire signed [16:0] smax = rev ? slo : shi;

    // range indicator per point
    wire rng_cur = scl ? (dat < smin) | (dat > smax)  // R18
                 : bip ? (dat < 17'(BIP_MIN)) | (dat > 17'(BIP_MAX))  // R17
                 : (dat < 17'sd0) | (dat > 17'(FS));  // R16

    // limits clamp in engineering units before scaling
    wire signed [16:0] lv = !lim ? dat
                          : (dat < llo) ? llo
                          : (dat > lhi) ? lhi : dat;  // R07 R08
    wire signed [16:0] sv = (lv < smin) ? smin : (lv > smax) ? smax : lv;
    wire signed [17:0] sdf = 18'(sv) - 18'(smin);
    wire signed [17:0] spn = 18'(smax) - 18'(smin);
    wire        [28:0] num = 29'(sdf[16:0]) * 29'(FS);
    wire        [16:0] den = (spn == 18'sd0) ? 17'h1 : spn[16:0];
    // reverse needs no extra path: span runs up from the smaller limit
    wire        [28:0] quo = num / 29'(den);  // R20 R04 R03
    wire signed [17:0] uv = bip ? 18'(lv) + 18'(BIP_OFS) : 18'(lv);
    wire        [11:0] ucode = (uv < 18'sd0) ? 12'h0
                             : (uv > 18'(FS)) ? 12'(FS) : uv[11:0];
    wire        [11:0] tgt = scl ? quo[11:0] : ucode;

    // settings check for the point being served
    wire rmax_ok = rmv <= (bcd ? 17'(RAMP_BCD_MAX) : 17'(RAMP_BIN_MAX));
    wire rmp_ok  = (rmv >= 17'(RAMP_MIN)) & rmax_ok;  // R06
    wire ch_err  = dw[RI_DATA][17]
                 | (scl & (dw[RI_SLO][17] | dw[RI_SHI][17] | spn == 0))
                 | (lim & (dw[RI_LLO][17] | dw[RI_LHI][17] | lhi <= llo))
                 | (rmp & (dw[RI_RAMP][17] | !rmp_ok));  // R09

    // ramp: step per service from ramp time, restart from present value
    wire [16:0] stq  = RAMP_K / ((rmv < 17'sd1) ? 17'h1 : rmv[16:0]);
    wire [11:0] step = (stq == 17'h0) ? 12'h1
                     : (stq > 17'(FS)) ? 12'(FS) : stq[11:0];
    wire [11:0] cur  = out_q[ch_q];
    wire [11:0] up_n = (tgt - cur <= step) ? tgt : cur + step;
    wire [11:0] dn_n = (cur - tgt <= step) ? tgt : cur - step;
    wire [11:0] nxt  = !rmp ? tgt : (tgt > cur) ? up_n : dn_n;  // R05 R22

    assign err_any = mem_err_q | !field_ok | hsc | (|set_err_q);
    wire halt0 = err_any | (!host_ok & !hold_sel);
    wire upd   = tick & running & host_ok;

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    // any error, or host loss without hold, drives zero; hold freezes on host loss
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            out_q <= '0;
        end else if (halt0) begin
            out_q <= '0;  // R14 R19
        end else if (upd) begin
            out_q[ch_q] <= nxt;  // R19
        end
    end

    // status per point is refreshed even while stopped so it can recover
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            set_err_q <= '0;
            rng_q     <= '0;
        end else if (tick & running) begin
            set_err_q[ch_q] <= ch_err;  // R15
            rng_q[ch_q]     <= rng_cur;
        end
    end

    // flash base for the indicators
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            blk_q   <= '0;
            blink_q <= 1'b0;
        end else begin
            blk_q <= (blk_q == BL_N) ? '0 : blk_q + 1'b1;
            if (blk_q == BL_N) blink_q <= !blink_q;
        end
    end

    // bad settings flash the error lamp, hard faults hold it lit
    wire wr_warn = wcnt_q >= 14'(WR_WARN);
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            run_q  <= 1'b0;
            errl_q <= 1'b0;
            rngl_q <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            run_q  <= !err_any & (!wr_warn | blink_q);  // R13 R14
            errl_q <= mem_err_q | !field_ok | hsc
                    | ((|set_err_q) & blink_q);  // R15
            rngl_q <= |rng_q;  // R16 R17 R18
            fast_q <= ctrl_q[CT_FAST] & !hsc;  // R10
        end
    end

    assign o_prdata    = rd_q;
    assign o_pready    = rdy_q;
    assign o_pslverr   = err_q;
    assign o_nv_req    = req_q;
    assign o_nv_we     = we_q;
    assign o_nv_addr   = idx_q;
    assign o_nv_wdata  = wdat_q;
    assign o_dac_code  = out_q;
    assign o_dac_fast  = fast_q;
    assign o_run_led   = run_q;
    assign o_err_led   = errl_q;
    assign o_range_led = rngl_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    AST_RUN_DARK: assert property (err_any |=> !o_run_led) // R14
        else $error("run lamp lit during error");
    AST_STOP_ZERO: assert property (err_any |=> o_dac_code == '0) // R14
        else $error("outputs not zero during error");
    AST_HS_REFUSE: assert property (hsc |=> !o_dac_fast) // R10
        else $error("high speed granted with slow feature");
    AST_RNG_LAMP: assert property (tick & running & rng_cur & !halt0
        |=> ##1 o_range_led) // R16
        else $error("range lamp not lit");
    AST_STORE_GO: assert property (store_req & running & !store_pend_q
        |=> ##1 nv_st_q == NV_STORE) // R11
        else $error("store not started");
    AST_WCNT: assert property (nv_st_q == NV_STORE & req_q & i_nv_ack
        & idx_q == 6'h3f & wcnt_q != WCNT_MAX
        |=> wcnt_q == $past(wcnt_q) + 14'h1) // R13
        else $error("store count not advanced");
    AST_LOAD_WR: assert property (ld_we & !ch_we
        |=> rf_q[$past(idx_q)] == $past(i_nv_rdata)) // R12
        else $error("load word not written");
    AST_RAMP: assert property (upd & !halt0 & rmp & (tgt > cur)
        |=> out_q[$past(ch_q)] > $past(cur)
        && out_q[$past(ch_q)] <= $past(tgt)) // R05
        else $error("ramp step out of bounds");
    AST_HOLD: assert property (!host_ok & hold_sel & !err_any
        |=> $stable(o_dac_code)) // R19
        else $error("held output moved");

    COV_STORE: cover property (nv_st_q == NV_RUN ##1 nv_st_q == NV_STORE);
    COV_LOAD: cover property (nv_st_q == NV_LOAD ##1 nv_st_q == NV_RUN);
    COV_RAMP: cover property (upd & rmp & (tgt != cur) & !halt0);
    COV_FAST: cover property (o_dac_fast);

endmodule

// >>> aop_nv_model.sv
`timescale 1ns/100ps
// non-volatile store stand-in: one word per request
module aop_nv_model (
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [5:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    output logic             o_ack,
    output logic [15:0]      o_rdata
);
    logic [15:0] mem [0:63] = '{default: 16'h0};  // bench preloads some
    logic [15:0] last_q = 16'h0;
    int          wait_n = 0;
    int          n_wr = 0;

    // read data only means something with ack, so it is inverted between
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~last_q;
        if (i_req && !o_ack) begin
            if (wait_n < (i_slow ? 5 : 0)) begin
                wait_n <= wait_n + 1;
            end else begin
                wait_n <= 0;
                o_ack <= 1'b1;
                if (i_we) begin
                    mem[i_addr] <= i_wdata;
                    n_wr <= n_wr + 1;
                end else begin
                    o_rdata <= mem[i_addr];
                    last_q <= mem[i_addr];
                end
            end
        end
    end
endmodule

// >>> analog_output_data_processor_test.sv
`timescale 1ns/100ps
module analog_output_data_processor_test
    import aop_pkg::*;
;
    logic                 clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic                 host_ok = 1, fld_ok = 1, hold = 0, slow = 0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0, prdata, rd;
    logic                 pready, pslverr, serr, nv_req, nv_we, nv_ack;
    logic [5:0]           nv_addr;
    logic [15:0]          nv_wdata, nv_rdata;
    logic [NCH-1:0][11:0] code;
    logic                 fast, run_led, err_led, rng_led;
    int                   err_count = 0, n_compared = 0;

    // short service and blink periods keep the run brief
    aop_core #(.P_CONV_CYC(80), .P_FAST_CYC(40), .P_BLINK_CYC(16)) u_aop_core (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_nv_req(nv_req),
        .o_nv_we(nv_we), .o_nv_addr(nv_addr), .o_nv_wdata(nv_wdata),
        .i_nv_ack(nv_ack), .i_nv_rdata(nv_rdata), .i_nv_err(1'b0),
        .i_host_pwr_ok(host_ok), .i_field_pwr_ok(fld_ok), .i_hold_sel(hold),
        .o_dac_code(code), .o_dac_fast(fast), .o_run_led(run_led),
        .o_err_led(err_led), .o_range_led(rng_led));
    aop_nv_model u_aop_nv_model (.i_clk(clk), .i_slow(slow), .i_req(nv_req),
        .i_we(nv_we), .i_addr(nv_addr), .i_wdata(nv_wdata), .o_ack(nv_ack),
        .o_rdata(nv_rdata));

    initial forever #5 clk = ~clk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is seen
    task apb(input logic wr, input logic [11:0] a,
             input logic [31:0] d = 32'h0);
        int n;
        n = 0;
        {psel, pwr, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        {rd, serr} = {prdata, pslverr};
        @(posedge clk);
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask
    function automatic logic [11:0] adr(input int p, input logic [2:0] r);
        return 12'(p * 32 + r * 4);
    endfunction
    // one round of all points plus lamp lag
    task settle;
        repeat (100) @(posedge clk);
    endtask
    task busy_wait;
        int n;
        n = 0;
        do begin
            apb(1'b0, A_STAT);
            n++;
        end while (rd[SB_BUSY] !== 1'b0 && n < 400);
        chk(rd[SB_BUSY], 1'b0);
    endtask
    task pt(input int p, input logic [15:0] cfg, input logic [15:0] d,
            input logic rng, input logic [11:0] exp);
        apb(1'b1, adr(p, RI_CFG), {16'h0, cfg});
        apb(1'b1, adr(p, RI_DATA), {16'h0, d});
        settle;
        apb(1'b0, A_STAT);
        chk(rd[SB_RNG + p], rng);
        apb(1'b0, adr(p, RI_OUT));
        chk(rd, {20'h0, exp});
        chk(code[p], exp);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_load;
        busy_wait;
        settle;
        chk(code[0], 12'd1000);
        chk(code[1], 12'd300);
        chk(run_led, 1'b1);
        apb(1'b0, 12'h10c);
        chk(serr, 1'b1);
        $display("load test done");
    endtask
    task t_range;
        pt(2, 16'h0, 16'd4096, 1'b1, 12'd4095);
        pt(2, 16'h0, 16'hffff, 1'b1, 12'd0);
        pt(2, 16'h0, 16'd4095, 1'b0, 12'd4095);
        pt(3, 16'h10, 16'hf7ff, 1'b1, 12'd0);
        pt(3, 16'h10, 16'd2048, 1'b1, 12'd4095);
        pt(3, 16'h10, 16'hf800, 1'b0, 12'd0);
        apb(1'b1, adr(4, RI_SLO), 32'd1000);
        apb(1'b1, adr(5, RI_SLO), 32'h8001);
        apb(1'b1, adr(5, RI_SHI), 32'h7fff);
        pt(4, 16'h2, 16'd0, 1'b0, 12'd0);
        pt(4, 16'h2, 16'd1000, 1'b0, 12'd4095);
        pt(4, 16'h2, 16'd1001, 1'b1, 12'd4095);
        pt(5, 16'h2, 16'h7fff, 1'b0, 12'd4095);
        pt(5, 16'h2, 16'h8001, 1'b0, 12'd0);
        pt(6, 16'h1, 16'h1234, 1'b0, 12'h4d2);
        pt(6, 16'h1, 16'hf001, 1'b1, 12'd0);
        apb(1'b1, adr(7, RI_LHI), 32'd200);
        apb(1'b1, adr(7, RI_LLO), 32'd100);
        pt(7, 16'h4, 16'd300, 1'b0, 12'd200);
        pt(7, 16'h4, 16'd50, 1'b0, 12'd100);
        $display("range test done");
    endtask
    task t_store;
        slow <= 1'b1;
        apb(1'b1, A_CTRL, 32'h2);
        busy_wait;
        chk(u_aop_nv_model.n_wr, 64);
        chk(u_aop_nv_model.mem[0], 32'd1000);
        apb(1'b0, A_WCNT);
        chk(rd, 32'd1);
        apb(1'b1, A_CTRL, 32'h0);
        slow <= 1'b0;
        $display("store test done");
    endtask
    task t_hold;
        {hold, host_ok} <= 2'b10;
        apb(1'b1, adr(0, RI_DATA), 32'd2000);
        settle;
        chk(code[0], 12'd1000);
        {hold, host_ok} <= 2'b01;
        settle;
        chk(code[0], 12'd2000);
        host_ok <= 1'b0;
        settle;
        chk(code[1], 12'd0);
        host_ok <= 1'b1;
        settle;
        $display("hold test done");
    endtask
    task t_ramp;
        apb(1'b1, adr(0, RI_RAMP), 32'd8);
        apb(1'b1, adr(0, RI_CFG), 32'h8);
        apb(1'b1, adr(0, RI_DATA), 32'd4000);
        settle;
        chk(code[0] == 12'd2511 || code[0] == 12'd3022, 1'b1);
        repeat (400) @(posedge clk);
        chk(code[0], 12'd4000);
        $display("ramp test done");
    endtask
    task t_err;
        fld_ok <= 1'b0;
        settle;
        chk({err_led, run_led, code[1]}, {2'b10, 12'd0});
        fld_ok <= 1'b1;
        settle;
        chk(run_led, 1'b1);
        apb(1'b1, A_CTRL, 32'h1);
        settle;
        apb(1'b0, A_STAT);
        chk({rd[SB_HSC], fast, err_led, run_led}, 4'b1010);
        for (int p = 0; p < NCH; p++) apb(1'b1, adr(p, RI_CFG), 32'h0);
        settle;
        apb(1'b0, A_STAT);
        chk({rd[SB_FAST], fast}, 2'b11);
        $display("error test done");
    endtask

    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        @(posedge clk);
        u_aop_nv_model.mem[0] = 16'd1000;
        u_aop_nv_model.mem[8] = 16'd300;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_load;
        t_range;
        t_store;
        t_hold;
        t_ramp;
        t_err;
        tally_and_finish;
    end
    // hang guard, far beyond a clean run
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish;
    end
endmodule
